// ===== common/ocd_map.svh
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH

// register byte offsets
`define OCD_CMD_OFS      8'h00
`define OCD_STATUS_OFS   8'h04
`define OCD_CTRL_OFS     8'h08
`define OCD_ERR_OFS      8'h0c
`define OCD_ADDR_OFS     8'h10
`define OCD_WIN_OFS      8'h14
`define OCD_PANEL_OFS    8'h18
`define OCD_TIMING_OFS   8'h1c

// field positions
`define OCD_STAT_OFF_BIT 6
`define OCD_ERR_UNDEF    0
`define OCD_ERR_PARAM    1

// reset values, and the smallest valid multiplex ratio
`define OCD_COL_END_RST  7'h7f
`define OCD_PAGE_END_RST 3'h7
`define OCD_MUX_RST      6'h3f
`define OCD_MUX_MIN      6'h0f
`define OCD_TRIM_RST     4'h7
`define OCD_PC_RST       4'h2
`define OCD_DESEL_RST    4'hd
`define OCD_GPIO_RST     2'h2

`endif

// ===== common/ocd_pkg.sv
package ocd_pkg;

   typedef enum logic [1:0] {
      ocd_horiz = 2'b00,
      ocd_vert  = 2'b01,
      ocd_page  = 2'b10
   } ocd_mode_t;

   typedef enum logic [1:0] {
      ocd_st_cmd  = 2'b00,
      ocd_st_par1 = 2'b01,
      ocd_st_par2 = 2'b10
   } ocd_state_t;

   typedef struct packed {
      ocd_mode_t   mode;
      logic [7:0]  page_col;
      logic [2:0]  page_sel;
      logic [6:0]  col_start;
      logic [6:0]  col_end;
      logic [2:0]  page_start;
      logic [2:0]  page_end;
      logic [5:0]  start_line;
      logic        seg_remap;
      logic [5:0]  mux_ratio;
      logic        com_reverse;
      logic [5:0]  disp_offset;
      logic        com_alt;
      logic        com_lr_swap;
      logic [1:0]  gpio_mode;
      logic [3:0]  clk_div;
      logic [3:0]  osc_trim;
      logic [3:0]  pc_phase1;
      logic [3:0]  pc_phase2;
      logic [3:0]  deselect;
   } ocd_cfg_t;

endpackage

// ===== hdl/ocd_decoder.sv
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
`include "ocd_map.svh"
// Operation
// - commands 00-0F load low nibble of page-mode column pointer, reset zero
// - commands 10-1F load high nibble of page-mode column pointer, reset zero
// - 20 plus parameter selects addressing mode; page by default; 11b invalid
// - 21 takes column start and end, 0 to 127, reset 0 and 127
// - 22 takes page start and end, 0 to 7, reset 0 and 7
// - B0-B7 set page-mode page pointer from low three bits
// - 40-7F load six-bit display start line
// - A0 maps column 0 to first segment, A1 reverses columns
// - A8 sets multiplex ratio N+1; reset 63; values 0-14 invalid
// - C0 scans rows upward, C8 downward; bit 3 selects
// - D3 sets six-bit vertical row offset, reset zero
// - DA bit 4 alternative layout (reset 1), bit 5 left/right swap
// - DC two-bit general pin control, reset drive low
// - D5 low nibble sets clock divide minus one, reset zero
// - D5 high nibble sets oscillator trim, reset 0111b
// - D9 nibbles set precharge phases 1-15, reset 2, zero invalid
// - DB bits 5:2 store deselect level code, reset 1101b
// - status byte bit 6 high while display off
module ocd_decoder
   import ocd_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output ocd_cfg_t         cfg,
   output logic             gpio_out,
   output logic             gpio_oe_n,
   input  wire logic        gpio_in
);

   logic       wr_pend;
   logic       rd_pend;
   logic [7:0] ap_addr;
   logic       cmd_stb;
   logic [7:0] cmd_byte;
   logic       display_on;
   logic [1:0] err;
   ocd_state_t state;
   logic [7:0] pend;
   logic       undef_hit;
   logic       param_hit;
   logic       gpio_m;
   logic       gpio_s;
   logic       gpio_in_seen;
   ocd_mode_t  mode;
   logic [7:0] page_col;
   logic [2:0] page_sel;
   logic [6:0] col_start;
   logic [6:0] col_end;
   logic [2:0] page_start;
   logic [2:0] page_end;
   logic [5:0] start_line;
   logic       seg_remap;
   logic [5:0] mux_ratio;
   logic       com_reverse;
   logic [5:0] disp_offset;
   logic       com_alt;
   logic       com_lr_swap;
   logic [1:0] gpio_mode;
   logic [3:0] clk_div;
   logic [3:0] osc_trim;
   logic [3:0] pc_phase1;
   logic [3:0] pc_phase2;
   logic [3:0] deselect;
   logic       set_cmd;
   logic       set_par1;
   logic       set_par2;

   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         `OCD_STATUS_OFS: w[`OCD_STAT_OFF_BIT] = ~display_on;
         `OCD_CTRL_OFS:   w[0] = display_on;
         `OCD_ERR_OFS:    w[1:0] = err;
         `OCD_ADDR_OFS:   w = {16'h0000, 2'b00, cfg.mode, 1'b0, cfg.page_sel, cfg.page_col};
         `OCD_WIN_OFS:    w = {9'h000, cfg.page_end, 1'b0, cfg.page_start,
                               1'b0, cfg.col_end, 1'b0, cfg.col_start};
         `OCD_PANEL_OFS:  w = {5'h00, gpio_in_seen, cfg.gpio_mode, cfg.com_lr_swap,
                               cfg.com_alt, cfg.disp_offset, 2'b00, cfg.mux_ratio,
                               cfg.com_reverse, cfg.seg_remap, cfg.start_line};
         `OCD_TIMING_OFS: w = {12'h000, cfg.deselect, cfg.pc_phase2, cfg.pc_phase1,
                               cfg.osc_trim, cfg.clk_div};
         default:         w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // parameter bytes that follow a command byte
   function automatic logic [1:0] param_count(input logic [7:0] c);
      logic [1:0] n;
      n = 2'h0;
      case (c)
         8'h21, 8'h22: n = 2'h2;
         8'h20, 8'ha8, 8'hd3, 8'hd5, 8'hd9, 8'hda, 8'hdb, 8'hdc: n = 2'h1;
         default: n = 2'h0;
      endcase
      return n;
   endfunction

   // out-of-range parameter bytes; the setting they carry is dropped
   function automatic logic param_bad(input logic [7:0] c, input logic [7:0] p,
                                      input logic second);
      logic bad;
      bad = 1'b0;
      case (c)
         8'h20:   bad = ~second & (p[1:0] == 2'b11);
         8'h21:   bad = p[7];
         8'ha8:   bad = ~second & (p[5:0] < `OCD_MUX_MIN);
         8'hd9:   bad = ~second & ((p[3:0] == 4'h0) | (p[7:4] == 4'h0));
         default: bad = 1'b0;
      endcase
      return bad;
   endfunction

   // bus address phase; reads get one wait state so earlier writes have landed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         ap_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel & htrans[1] & hwrite;
         rd_pend <= hsel & htrans[1] & ~hwrite;
         ap_addr <= haddr;
      end else begin
         rd_pend <= 1'b0;
      end
   end

   // reads stall one cycle; writes never stall
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         hresp     <= 1'b0;
         hreadyout <= ~(hready & hsel & htrans[1] & ~hwrite);
         if (rd_pend) begin
            hrdata <= read_word(ap_addr);
         end
      end
   end

   assign cmd_stb  = wr_pend & (ap_addr == `OCD_CMD_OFS);
   assign cmd_byte = hwdata[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         display_on <= 1'b0;
      end else if (wr_pend && ap_addr == `OCD_CTRL_OFS) begin
         display_on <= hwdata[0];
      end
   end

   // classify the incoming byte for the error flags
   always_comb begin
      undef_hit = 1'b0;
      param_hit = 1'b0;
      if (cmd_stb) begin
         unique case (state)
            ocd_st_cmd: begin
               casez (cmd_byte)
                  8'b000?_????, 8'b01??_????, 8'b1011_0???,
                  8'ha0, 8'ha1, 8'hc0, 8'hc8: undef_hit = 1'b0;
                  default: undef_hit = (param_count(cmd_byte) == 2'h0);
               endcase
            end
            ocd_st_par1: param_hit = param_bad(pend, cmd_byte, 1'b0);
            ocd_st_par2: param_hit = param_bad(pend, cmd_byte, 1'b1);
            default:     param_hit = 1'b0;
         endcase
      end
   end

   // sticky flags, write one to clear; a new event wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err <= 2'b00;
      end else begin
         if (wr_pend && ap_addr == `OCD_ERR_OFS) begin
            err <= (err & ~hwdata[1:0]) | {param_hit, undef_hit};
         end else begin
            err <= err | {param_hit, undef_hit};
         end
      end
   end

   // command sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ocd_st_cmd;
         pend  <= 8'h00;
      end else if (cmd_stb) begin
         unique case (state)
            ocd_st_cmd: begin
               if (param_count(cmd_byte) != 2'h0) begin
                  pend  <= cmd_byte;
                  state <= ocd_st_par1;
               end
            end
            ocd_st_par1: begin
               if (param_count(pend) == 2'h2) begin
                  state <= ocd_st_par2;
               end else begin
                  state <= ocd_st_cmd;
               end
            end
            ocd_st_par2: state <= ocd_st_cmd;
            default:     state <= ocd_st_cmd;
         endcase
      end
   end

   // bytes accepted at each position; a rejected byte still advances the sequencer
   assign set_cmd  = cmd_stb & ~param_hit & (state == ocd_st_cmd);
   assign set_par1 = cmd_stb & ~param_hit & (state == ocd_st_par1);
   assign set_par2 = cmd_stb & ~param_hit & (state == ocd_st_par2);

   // addressing pointers and mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode       <= ocd_page;
         page_col   <= 8'h00;
         page_sel   <= 3'h0;
         col_start  <= 7'h00;
         col_end    <= `OCD_COL_END_RST;
         page_start <= 3'h0;
         page_end   <= `OCD_PAGE_END_RST;
      end else if (set_cmd) begin
         casez (cmd_byte)
            8'b0000_????: page_col[3:0] <= cmd_byte[3:0];
            8'b0001_????: page_col[7:4] <= cmd_byte[3:0];
            8'b1011_0???: page_sel <= cmd_byte[2:0];
            default: ;
         endcase
      end else if (set_par1) begin
         case (pend)
            8'h20: mode <= ocd_mode_t'(cmd_byte[1:0]);
            8'h21: col_start <= cmd_byte[6:0];
            8'h22: page_start <= cmd_byte[2:0];
            default: ;
         endcase
      end else if (set_par2) begin
         case (pend)
            8'h21: col_end <= cmd_byte[6:0];
            8'h22: page_end <= cmd_byte[2:0];
            default: ;
         endcase
      end
   end

   // panel layout
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_line  <= 6'h00;
         seg_remap   <= 1'b0;
         mux_ratio   <= `OCD_MUX_RST;
         com_reverse <= 1'b0;
         disp_offset <= 6'h00;
         com_alt     <= 1'b1;
         com_lr_swap <= 1'b0;
      end else if (set_cmd) begin
         casez (cmd_byte)
            8'b01??_????: start_line <= cmd_byte[5:0];
            8'b1010_000?: seg_remap <= cmd_byte[0];
            8'b1100_?000: com_reverse <= cmd_byte[3];
            default: ;
         endcase
      end else if (set_par1) begin
         case (pend)
            8'ha8: mux_ratio <= cmd_byte[5:0];
            8'hd3: disp_offset <= cmd_byte[5:0];
            8'hda: begin
               com_alt     <= cmd_byte[4];
               com_lr_swap <= cmd_byte[5];
            end
            default: ;
         endcase
      end
   end

   // general pin mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpio_mode <= `OCD_GPIO_RST;
      end else if (set_par1 && pend == 8'hdc) begin
         gpio_mode <= cmd_byte[1:0];
      end
   end

   // display timing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_div   <= 4'h0;
         osc_trim  <= `OCD_TRIM_RST;
         pc_phase1 <= `OCD_PC_RST;
         pc_phase2 <= `OCD_PC_RST;
         deselect  <= `OCD_DESEL_RST;
      end else if (set_par1) begin
         case (pend)
            8'hd5: begin
               clk_div  <= cmd_byte[3:0];
               osc_trim <= cmd_byte[7:4];
            end
            8'hd9: begin
               pc_phase1 <= cmd_byte[3:0];
               pc_phase2 <= cmd_byte[7:4];
            end
            8'hdb: deselect <= cmd_byte[5:2];
            default: ;
         endcase
      end
   end

   // settings leave the block straight from their flip-flops
   assign cfg = '{
      mode:        mode,
      page_col:    page_col,
      page_sel:    page_sel,
      col_start:   col_start,
      col_end:     col_end,
      page_start:  page_start,
      page_end:    page_end,
      start_line:  start_line,
      seg_remap:   seg_remap,
      mux_ratio:   mux_ratio,
      com_reverse: com_reverse,
      disp_offset: disp_offset,
      com_alt:     com_alt,
      com_lr_swap: com_lr_swap,
      gpio_mode:   gpio_mode,
      clk_div:     clk_div,
      osc_trim:    osc_trim,
      pc_phase1:   pc_phase1,
      pc_phase2:   pc_phase2,
      deselect:    deselect
   };

   // general pin: enable low while driving
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpio_out  <= 1'b0;
         gpio_oe_n <= 1'b0;
      end else begin
         gpio_out  <= cfg.gpio_mode[0];
         gpio_oe_n <= ~cfg.gpio_mode[1];
      end
   end

   // two-stage synchroniser; only the second stage is read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpio_m       <= 1'b0;
         gpio_s       <= 1'b0;
         gpio_in_seen <= 1'b0;
      end else begin
         gpio_m       <= gpio_in;
         gpio_s       <= gpio_m;
         gpio_in_seen <= gpio_s & (cfg.gpio_mode == 2'b01);
      end
   end

endmodule

// ===== dv/ocd_decoder_monitor.sv
`timescale 1ns/1ns
module ocd_decoder_monitor
   import ocd_pkg::*;
(
   input wire logic     hclk,
   input wire logic     hresetn,
   input wire logic     hsel,
   input wire logic [1:0] htrans,
   input wire logic     hwrite,
   input wire logic     hready,
   input wire logic     hreadyout,
   input wire logic     hresp,
   input wire ocd_cfg_t cfg,
   input wire logic     gpio_out,
   input wire logic     gpio_oe_n
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic taken;
   assign taken = hsel && hready && htrans[1];
   property p_read_wait;
      taken && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
   property p_write_fast;
      taken && hwrite |=> hreadyout;
   endproperty
   a_write_fast: assert property (p_write_fast) else $error("write stalled");
   property p_wait_one;
      !hreadyout |=> hreadyout;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait too long");
   property p_okay;
      !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_gpio_oe;
      gpio_oe_n == !$past(cfg.gpio_mode[1]);
   endproperty
   a_gpio_oe: assert property (p_gpio_oe) else $error("pin enable wrong");
   property p_gpio_lvl;
      !gpio_oe_n |-> gpio_out == $past(cfg.gpio_mode[0]);
   endproperty
   a_gpio_lvl: assert property (p_gpio_lvl) else $error("pin level wrong");
   property p_mode_ok;
      cfg.mode != 2'b11;
   endproperty
   a_mode_ok: assert property (p_mode_ok) else $error("bad mode held");
   property p_mux_ok;
      cfg.mux_ratio >= 6'h0f;
   endproperty
   a_mux_ok: assert property (p_mux_ok) else $error("bad mux held");
   property p_pc_ok;
      cfg.pc_phase1 != 4'h0 && cfg.pc_phase2 != 4'h0;
   endproperty
   a_pc_ok: assert property (p_pc_ok) else $error("zero precharge held");
   c_read: cover property (taken && !hwrite);
   c_horiz: cover property (cfg.mode == ocd_horiz);
   c_high: cover property (!gpio_oe_n && gpio_out);
endmodule

bind ocd_decoder ocd_decoder_monitor u_mon (.hclk, .hresetn, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .cfg, .gpio_out, .gpio_oe_n);

// ===== dv/ocd_host_model.sv
`timescale 1ns/1ns
module ocd_host_model (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [7:0]       haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   int gap = 0;
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      repeat (gap) @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
      hwdata <= ~d;
   endtask
   // defined bytes only, parameters follow on the command path
   task cmd(input logic [7:0] b);
      logic [31:0] q;
      xfer(8'h00, 1'b1, {24'h0, b}, q);
   endtask
endmodule

// ===== dv/ocd_decoder_tb_top.sv
`timescale 1ns/1ns
`include "ocd_map.svh"
module ocd_decoder_tb_top;
   import ocd_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        gpio_out, gpio_oe_n, gpio_in;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, q;
   ocd_cfg_t    cfg;
   int          errors = 0, samples_checked = 0, cycles = 0;
   assign hready = hreadyout;
   ocd_decoder DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .cfg, .gpio_out, .gpio_oe_n, .gpio_in);
   ocd_host_model HOST (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata);
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         stop_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("errors %0d checks %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task rd(input logic [7:0] a);
      HOST.xfer(a, 1'b0, 32'h0, q);
   endtask
   task seq(input logic [63:0] s, input int n);
      for (int i = n - 1; i >= 0; i--) HOST.cmd(s[8*i+:8]);
   endtask
   task t_reset;
      rd(`OCD_ADDR_OFS);
      chk(q, 32'h2000);
      rd(`OCD_WIN_OFS);
      chk(q, 32'h707f00);
      rd(`OCD_PANEL_OFS);
      chk(q, 32'h02403f00);
      rd(`OCD_TIMING_OFS);
      chk(q, 32'hd2270);
      rd(`OCD_STATUS_OFS);
      chk(q & 32'h40, 32'h40);
      chk({30'h0, gpio_oe_n, gpio_out}, 32'h0);
   endtask
   task t_addr;
      seq(64'h0a1cb5, 3);
      rd(`OCD_ADDR_OFS);
      chk(q, 32'h25ca);
      seq(64'h2003_20fd, 4);
      rd(`OCD_ADDR_OFS);
      chk(q, 32'h15ca);
      seq(64'h20fc, 2);
      rd(`OCD_ADDR_OFS);
      chk(q, 32'h05ca);
      seq(64'h21057f, 3);
      seq(64'h22fa06, 3);
      seq(64'h218010, 3);
      rd(`OCD_WIN_OFS);
      chk(q, 32'h621005);
      rd(`OCD_ERR_OFS);
      chk(q, 32'h2);
      HOST.xfer(`OCD_ERR_OFS, 1'b1, 32'h3, q);
      rd(`OCD_ERR_OFS);
      chk(q, 32'h0);
   endtask
   task t_panel;
      seq(64'h7fa1a80ea80fc8d3, 8);
      seq(64'h3fda20d5f3d90fd9, 8);
      seq(64'h1fdb3c, 3);
      rd(`OCD_PANEL_OFS);
      chk(q, 32'h02bf0fff);
      rd(`OCD_TIMING_OFS);
      chk(q, 32'hf1ff3);
      seq(64'ha0c0, 2);
      rd(`OCD_PANEL_OFS);
      chk(q, 32'h02bf0f3f);
   endtask
   task t_gpio;
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         seq({56'h0, 6'h37, m} | 64'hdc00, 2);
         repeat (4) @(posedge hclk);
         chk({30'h0, gpio_oe_n, gpio_out & m[1]}, {30'h0, ~m[1], m[0] & m[1]});
         rd(`OCD_PANEL_OFS);
         chk(q & 32'h4000000, {5'h0, m == 2'b01 && gpio_in, 26'h0});
      end
      gpio_in <= 1'b0;
      seq(64'hdcdd, 2);
      repeat (4) @(posedge hclk);
      chk({31'h0, gpio_oe_n}, 32'h1);
      rd(`OCD_PANEL_OFS);
      chk(q & 32'h7000000, 32'h1000000);
   endtask
   task t_status;
      HOST.xfer(`OCD_CTRL_OFS, 1'b1, 32'h1, q);
      rd(`OCD_STATUS_OFS);
      chk(q & 32'h40, 32'h0);
      HOST.gap = 3;
      HOST.xfer(`OCD_CTRL_OFS, 1'b1, 32'h0, q);
      rd(`OCD_STATUS_OFS);
      chk(q & 32'h40, 32'h40);
      rd(8'h40);
      chk(q, 32'h0);
      HOST.gap = 0;
   endtask
   initial begin
      hresetn = 1'b0;
      gpio_in = 1'b1;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_addr();
      t_panel();
      t_gpio();
      t_status();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      stop_test();
   end
endmodule
